// ### bench/hw_limit_switch_monitor_bench.sv
`timescale 1ns/1ps
module hw_limit_switch_monitor_bench;
  logic core_clk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, faultReset = 0;
  logic powerStageEnabled = 0, moveCmdPos = 0, moveCmdNeg = 0;
  logic posHit = 0, negHit = 0;
  logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, got;
  logic [2:0] quick_stop_reaction = 3'h5;
  wire [15:0] regRdData;
  wire [3:0] limitErrorClass;
  wire [2:0] quickStopKind;
  wire regRdValid, regWrAck, regWrRejected, quickStopReq, limitError;
  wire posBlocked, negBlocked, allowPos, allowNeg;
  wire positive_travel_input, negative_travel_input;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  // Clock, device and contacts
  always #10 core_clk = ~core_clk;
  hw_limit_switch_monitor u_dut (.*);
  limit_contacts u_sw (.*);
  task chk(string n, logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task step(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Strobe for one edge; spare cycle keeps strobes apart
  task wr(logic [15:0] a, d);
    regWrEn = 1;
    regAddr = a;
    regWrData = d;
    step(1);
    regWrEn = 0;
    chk("wrAck", regWrAck, 1'b1);
    got = {15'h0000, regWrRejected};
    step(1);
  endtask
  task rd(logic [15:0] a);
    regRdEn = 1;
    regAddr = a;
    step(1);
    regRdEn = 0;
    chk("rdValid", regRdValid, 1'b1);
    got = regRdData;
    step(1);
  endtask
  task t_trip;
    powerStageEnabled = 1;
    step(2);
    chk("err", limitError, 1'b0);
    posHit = 1;
    step(4);
    chk("stop", quickStopReq, 1'b1);
    chk("class", limitErrorClass, 4'h1);
    chk("kind", quickStopKind, 3'h5);
    chk("allowPos", allowPos, 1'b0);
    chk("posBlk", posBlocked, 1'b1);
    chk("allowNeg", allowNeg, 1'b1);
    chk("negBlk", negBlocked, 1'b0);
    posHit = 0;
    moveCmdNeg = 1;
    step(5);
    chk("stop", quickStopReq, 1'b0);
    chk("err", limitError, 1'b1);
    moveCmdNeg = 0;
    moveCmdPos = 1;
    step(2);
    chk("stop", quickStopReq, 1'b1);
    moveCmdPos = 0;
    faultReset = 1;
    step(1);
    faultReset = 0;
    step(1);
    chk("err", limitError, 1'b0);
  endtask
  // Writes refused while powered; new type waits for next enable
  task t_regs;
    wr(16'h0620, 16'h0002);
    chk("rej", got, 16'h0001);
    powerStageEnabled = 0;
    wr(16'h0620, 16'h0003);
    chk("rej", got, 16'h0001);
    wr(16'h064A, 16'h0004);
    chk("rej", got, 16'h0001);
    wr(16'h0620, 16'h0002);
    chk("rej", got, 16'h0000);
    rd(16'h0620);
    chk("pos", got, 16'h0002);
    chk("err", limitError, 1'b0);
    powerStageEnabled = 1;
    step(5);
    chk("err", limitError, 1'b1);
  endtask
  task t_bypass;
    powerStageEnabled = 0;
    wr(16'h0620, 16'h0000);
    wr(16'h064A, 16'h0002);
    powerStageEnabled = 1;
    faultReset = 1;
    step(6);
    faultReset = 0;
    posHit = 1;
    negHit = 1;
    step(4);
    chk("err", limitError, 1'b0);
    chk("allowPos", allowPos, 1'b1);
    wr(16'h064A, 16'h0000);
    step(3);
    chk("negBlk", negBlocked, 1'b1);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    step(2);
    resetn = 1;
    step(1);
    rd(16'h0620);
    chk("pos", got, 16'h0001);
    rd(16'h061E);
    chk("neg", got, 16'h0001);
    rd(16'h064A);
    chk("byp", got, 16'h0000);
    rd(16'h0700);
    chk("unmapped", got, 16'h0000);
    t_trip;
    t_regs;
    t_bypass;
    complete_run;
  end
  // Hang guard, well above the run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      complete_run;
    end
  end
endmodule // hw_limit_switch_monitor_bench

// ### bench/limit_chk.sv
`timescale 1ns/1ps
// Port checks of the limit monitor
module limit_chk (
  // Clock, reset, controls and the reported quick stop kind
  input wire logic        core_clk, resetn, regWrEn, faultReset,
  input wire logic        powerStageEnabled, moveCmdPos,
  input wire logic [15:0] regAddr, regWrData,
  input wire logic [2:0]  quick_stop_reaction, quickStopKind,
  // Reactions
  input wire logic        regWrRejected, quickStopReq, limitError,
  input wire logic        posBlocked, negBlocked, allowPos, allowNeg,
  input wire logic [3:0]  limitErrorClass
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_cls; limitError |-> limitErrorClass == 4'h1; endproperty
  a_cls: assert property (p_cls) else $error("class");
  property p_hold; limitError && !faultReset |=> limitError; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_allow; allowPos != posBlocked && allowNeg != negBlocked;
  endproperty
  a_allow: assert property (p_allow) else $error("allow");
  property p_stop; $rose(quickStopReq) |-> limitError; endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_fwd; posBlocked && moveCmdPos |=> quickStopReq && limitError;
  endproperty
  a_fwd: assert property (p_fwd) else $error("fwd");
  // Kind is taken at the event, on the same edge the error shows
  property p_kind;
    $rose(limitError) |-> quickStopKind == $past(quick_stop_reaction);
  endproperty
  a_kind: assert property (p_kind) else $error("kind");
  property p_byp;
    regWrEn && regAddr == 16'h064A && regWrData > 16'h0003 |=> regWrRejected;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_lock;
    regWrEn && powerStageEnabled && regAddr == 16'h0620 |=> regWrRejected;
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
endmodule // limit_chk
bind hw_limit_switch_monitor limit_chk u_chk (.*);

// ### bench/limit_contacts.sv
`timescale 1ns/1ps
// NC contacts: actuation opens the circuit
module limit_contacts (
  input  wire logic posHit, negHit,
  output wire logic positive_travel_input, negative_travel_input
);
  // Both functions wired; closed contact reads high
  assign positive_travel_input = ~posHit;
  assign negative_travel_input = ~negHit;
endmodule // limit_contacts

// ### design/hw_limit_switch_monitor.v
`timescale 1ns/1ps
`include "limit_monitor_defines.vh"
// Hardware limit switch supervision for one drive axis
module hw_limit_switch_monitor (
  // Clock and reset
  input  wire        core_clk,
  input  wire        resetn,
  // Limit switch pins, asynchronous
  input  wire        positive_travel_input,
  input  wire        negative_travel_input,
  // Parameter access
  input  wire        regWrEn,
  input  wire        regRdEn,
  input  wire [15:0] regAddr,
  input  wire [15:0] regWrData,
  output reg  [15:0] regRdData,
  output reg         regRdValid,
  output reg         regWrAck,
  output reg         regWrRejected,
  // Power stage and motion
  input  wire        powerStageEnabled,
  input  wire        moveCmdPos,
  input  wire        moveCmdNeg,
  input  wire        faultReset,
  input  wire [2:0]  quick_stop_reaction,
  // Reactions
  output reg         quickStopReq,
  output reg  [2:0]  quickStopKind,
  output wire        limitError,
  output wire [3:0]  limitErrorClass,
  output wire        posBlocked,
  output wire        negBlocked,
  output wire        allowPos,
  output wire        allowNeg
);

  reg [1:0]  posEvalStore_q;
  reg [1:0]  negEvalStore_q;
  reg [1:0]  bypass_q;
  reg [1:0]  posEvalLive_q;
  reg [1:0]  negEvalLive_q;
  reg        powerPrev_q;
  reg        error_q;
  reg        posBlocked_q;
  reg        negBlocked_q;
  reg  [1:0] arm_q;
  wire [1:0] pinSync;
  wire       posTrig;
  wire       negTrig;
  wire       errorEvent;
  wire       enableEdge;
  wire       decodeHit;
  wire       valueOk;

  // Triggered level from contact type and pin level
  function trig;
    input [1:0] eval;
    input       pin;
    begin
      case (eval)
        `EVAL_NC: trig = ~pin; // see [R16]
        `EVAL_NO: trig = pin;  // see [R16]
        default:  trig = 1'b0;
      endcase
    end
  endfunction

  // Pins pass two flops before any decision
  limit_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .asyncIn  ({negative_travel_input, positive_travel_input}),
    .syncOut  (pinSync)
  );

  // Synchroniser resets low; mask triggers until real levels arrive
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      arm_q <= 2'h0;
    end else begin
      arm_q <= {arm_q[0], 1'b1};
    end
  end

  // Live evaluation and bypass gate each switch
  assign posTrig = trig(posEvalLive_q, pinSync[0]) & arm_q[1] &
                   ~bypass_q[`BYPASS_POS_BIT]; // see [R1] see [R14]
  assign negTrig = trig(negEvalLive_q, pinSync[1]) & arm_q[1] &
                   ~bypass_q[`BYPASS_NEG_BIT]; // see [R1] see [R14]

  // Forbidden motion counts only while the block stands
  assign errorEvent = posTrig | negTrig |
                      (moveCmdPos & posBlocked_q) |
                      (moveCmdNeg & negBlocked_q); // see [R6]
  assign enableEdge = powerStageEnabled & ~powerPrev_q;

  // Register decode and range check
  assign decodeHit = (regAddr == `REG_POS_EVAL) |
                     (regAddr == `REG_NEG_EVAL) |
                     (regAddr == `REG_BYPASS);
  assign valueOk = (regAddr == `REG_BYPASS) ?
                   (regWrData <= `BYPASS_MAX) :
                   ((regWrData <= `EVAL_MAX) &
                    ~powerStageEnabled); // see [R10] see [R17]

  // Stored settings; bypass has no power stage lock
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      posEvalStore_q <= `RST_POS_EVAL;
      negEvalStore_q <= `RST_NEG_EVAL;
      bypass_q       <= `RST_BYPASS;
    end else if (regWrEn && decodeHit && valueOk) begin
      case (regAddr)
        `REG_POS_EVAL: posEvalStore_q <= regWrData[1:0]; // see [R8]
        `REG_NEG_EVAL: negEvalStore_q <= regWrData[1:0]; // see [R9]
        `REG_BYPASS:   bypass_q <= regWrData[1:0]; // see [R12] see [R13]
        default:       bypass_q <= bypass_q;
      endcase
    end
  end

  // Evaluation copied in only at power stage enable
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      posEvalLive_q <= `RST_POS_EVAL;
      negEvalLive_q <= `RST_NEG_EVAL;
      powerPrev_q   <= 1'b0;
    end else begin
      powerPrev_q <= powerStageEnabled;
      if (enableEdge) begin
        posEvalLive_q <= posEvalStore_q; // see [R11]
        negEvalLive_q <= negEvalStore_q; // see [R11]
      end
    end
  end

  // Error and direction locks; a new event beats fault reset
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      error_q      <= 1'b0;
      posBlocked_q <= 1'b0;
      negBlocked_q <= 1'b0;
    end else begin
      if (errorEvent)
        error_q <= 1'b1; // see [R3]
      else if (faultReset)
        error_q <= 1'b0; // see [R4]
      if (posTrig)
        posBlocked_q <= 1'b1; // see [R5]
      else if (faultReset)
        posBlocked_q <= 1'b0;
      if (negTrig)
        negBlocked_q <= 1'b1; // see [R5]
      else if (faultReset)
        negBlocked_q <= 1'b0;
    end
  end

  // Quick stop follows any active trigger
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      quickStopReq  <= 1'b0;
      quickStopKind <= 3'h0;
    end else begin
      quickStopReq <= posTrig | negTrig |
                      (moveCmdPos & posBlocked_q) |
                      (moveCmdNeg & negBlocked_q); // see [R2]
      if (errorEvent)
        quickStopKind <= quick_stop_reaction; // see [R7]
    end
  end

  // Register answers, one cycle after the strobe
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData     <= 16'h0000;
      regRdValid    <= 1'b0;
      regWrAck      <= 1'b0;
      regWrRejected <= 1'b0;
    end else begin
      regRdValid    <= regRdEn;
      regWrAck      <= regWrEn;
      regWrRejected <= regWrEn & ~(decodeHit & valueOk); // see [R17]
      if (regRdEn) begin
        case (regAddr)
          `REG_POS_EVAL: regRdData <= {14'h0000, posEvalStore_q};
          `REG_NEG_EVAL: regRdData <= {14'h0000, negEvalStore_q};
          `REG_BYPASS:   regRdData <= {14'h0000, bypass_q};
          default:       regRdData <= 16'h0000;
        endcase
      end
    end
  end

  assign limitError      = error_q;
  assign limitErrorClass = error_q ? `LIMIT_ERR_CLASS : 4'h0; // see [R3]
  assign posBlocked      = posBlocked_q;
  assign negBlocked      = negBlocked_q;
  assign allowPos        = ~posBlocked_q; // see [R5]
  assign allowNeg        = ~negBlocked_q; // see [R5]

endmodule // hw_limit_switch_monitor

// ### design/limit_monitor_defines.vh
// Function
// [R1] Watch two limit inputs, one per travel direction.
// [R2] A triggered active switch issues a quick stop request.
// [R3] A trigger raises a class 1 error, held until cleared.
// [R4] The error stays set until a fault reset command clears it.
// [R5] After a trigger only motion away from that switch is allowed.
// [R6] Motion commanded toward a triggered switch raises a new class 1 error.
// [R7] Quick stop deceleration kind comes from a separate reaction setting.
// [R8] Positive evaluation: 0 ignored, 1 normally closed, 2 normally open; reset 1.
// [R9] Negative evaluation uses the same encoding; reset 1.
// [R10] Evaluation writes accepted only while the power stage is disabled.
// [R11] New evaluation values act from the next power stage enable.
// [R12] Bypass: 0 none, 1 positive, 2 negative, 3 both; reset 0.
// [R13] Bypass changes act at once.
// [R14] A bypassed switch gives neither quick stop nor error.
// [R15] Controller must assign limit input functions to physical inputs first.
// [R16] Triggered: normally closed input low, or normally open input high.
// [R17] Evaluation above 2 or bypass above 3 is rejected; old value kept.
`ifndef LIMIT_MONITOR_DEFINES_VH
`define LIMIT_MONITOR_DEFINES_VH

// Register offsets
`define REG_NEG_EVAL      16'h061E
`define REG_POS_EVAL      16'h0620
`define REG_BYPASS        16'h064A
// Reset values
`define RST_NEG_EVAL      2'h1
`define RST_POS_EVAL      2'h1
`define RST_BYPASS        2'h0
// Evaluation encodings
`define EVAL_IGNORED      2'h0
`define EVAL_NC           2'h1
`define EVAL_NO           2'h2
`define EVAL_MAX          16'h0002
`define BYPASS_MAX        16'h0003
// Bypass bit positions
`define BYPASS_POS_BIT    0
`define BYPASS_NEG_BIT    1
// Error class reported
`define LIMIT_ERR_CLASS   4'h1

`endif

// ### design/limit_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module limit_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             resetn,
  // Levels
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // First stage feeds only the second
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule // limit_sync
